// file: hdl/phy_mgmt_regs.sv
// Management register bank: interrupt enables and flags, crossover control,
// interrupt pin level, jabber counter enable and resolved link status.
// Assumes a management host clocking frames on mdc far slower than mclk,
// and event pulses and status levels from logic on mclk.
`timescale 1ns/1ps
module phy_mgmt_regs #(
	parameter logic [4:0] PHY_ADDRESS = 5'h01
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic evt_jabber,
	input wire logic evt_rx_error,
	input wire logic evt_page_received,
	input wire logic evt_parallel_fault,
	input wire logic evt_partner_ack,
	input wire logic evt_link_down,
	input wire logic evt_remote_fault,
	input wire logic evt_link_up,
	input wire logic speed_1000,
	input wire logic speed_100,
	input wire logic speed_10,
	input wire logic full_duplex,
	input wire logic gig_master,
	input wire logic link_check_fail,
	output logic int_pin,
	output logic auto_crossover_en,
	output logic force_mdi,
	output logic force_mdix,
	output logic jabber_count_en
);
	import phy_regs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pins_sync;
	logic mdc_prev_ff;
	logic mdc_rise;
	logic mdio_bit;

	sync_two_ff #(.WIDTH(2)) u_pin_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({mdc, mdio_in}),
		.sync_out(pins_sync)
	);

	assign mdio_bit = pins_sync[0];
	assign mdc_rise = pins_sync[1] & ~mdc_prev_ff;

	always_ff @(posedge mclk) begin
		if (reset) begin
			mdc_prev_ff <= 1'b0;
		end else begin
			mdc_prev_ff <= pins_sync[1];
		end
	end

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	event_flag_if ef ();
	logic rd_clr_ff;

	assign ef.evt = {evt_jabber, evt_rx_error, evt_page_received, evt_parallel_fault,
		evt_partner_ack, evt_link_down, evt_remote_fault, evt_link_up};
	assign ef.rd_clr = rd_clr_ff;

	event_flag_store u_flags (
		.mclk(mclk),
		.reset(reset),
		.ef(ef)
	);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [NUM_EVENTS-1:0] int_en_ff;
	logic xover_select_ff;
	logic xover_off_ff;
	logic int_level_ff;
	logic jabber_en_ff;
	logic [4:0] speed_dup_ff;
	logic link_fail_ff;
	logic wr_strobe_ff;
	logic [4:0] wr_reg_ff;
	logic [15:0] wr_data_ff;

	always_ff @(posedge mclk) begin
		if (reset) begin
			int_en_ff <= RST_INT_ENABLES;
		end else if (wr_strobe_ff && wr_reg_ff == ADDR_INT_ENABLE_AND_FLAGS) begin
			int_en_ff <= wr_data_ff[INT_EN_LSB +: NUM_EVENTS];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			xover_select_ff <= RST_XOVER_SELECT;
			xover_off_ff <= RST_XOVER_OFF;
		end else if (wr_strobe_ff && wr_reg_ff == ADDR_CROSSOVER_CONTROL) begin
			xover_select_ff <= wr_data_ff[XOVER_SELECT_BIT];
			xover_off_ff <= wr_data_ff[XOVER_OFF_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			int_level_ff <= RST_INT_LEVEL;
			jabber_en_ff <= RST_JABBER_EN;
		end else if (wr_strobe_ff && wr_reg_ff == ADDR_PHY_CONTROL_AND_STATUS) begin
			int_level_ff <= wr_data_ff[CTL_INT_LEVEL_BIT];
			jabber_en_ff <= wr_data_ff[CTL_JABBER_EN_BIT];
		end
	end

	// Resolved status is sampled so it reads as zero while in reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			speed_dup_ff <= 5'h00;
			link_fail_ff <= 1'b0;
		end else begin
			speed_dup_ff <= {speed_1000, speed_100, speed_10, full_duplex, gig_master};
			link_fail_ff <= link_check_fail;
		end
	end

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	function automatic logic [15:0] read_word(input logic [4:0] reg_addr);
		logic [15:0] w;
		w = READ_UNMAPPED;
		case (reg_addr)
			ADDR_INT_ENABLE_AND_FLAGS: begin
				w[INT_EN_LSB +: NUM_EVENTS] = int_en_ff;
				// An event stored in the capture cycle is cleared next cycle, so report it now
				w[INT_FLAG_LSB +: NUM_EVENTS] = ef.flags | ef.evt;
			end
			ADDR_CROSSOVER_CONTROL: begin
				w[XOVER_SELECT_BIT] = xover_select_ff;
				w[XOVER_OFF_BIT] = xover_off_ff;
			end
			ADDR_PHY_CONTROL_AND_STATUS: begin
				w[CTL_INT_LEVEL_BIT] = int_level_ff;
				w[CTL_JABBER_EN_BIT] = jabber_en_ff;
				w[CTL_SPEED_1000_BIT] = speed_dup_ff[4];
				w[CTL_SPEED_100_BIT] = speed_dup_ff[3];
				w[CTL_SPEED_10_BIT] = speed_dup_ff[2];
				w[CTL_DUPLEX_BIT] = speed_dup_ff[1];
				w[CTL_MASTER_BIT] = speed_dup_ff[0];
				w[CTL_LINK_FAIL_BIT] = link_fail_ff;
			end
			default: begin
				w = READ_UNMAPPED;
			end
		endcase
		return w;
	endfunction : read_word

	// ----------------------------------------------------------------
	// Management frame engine
	// ----------------------------------------------------------------
	// Every frame needs a full preamble; preamble suppression is not supported
	frame_state_e state_ff;
	logic [5:0] pre_cnt_ff;
	logic [3:0] bit_cnt_ff;
	logic [1:0] op_ff;
	logic [9:0] addr_ff;
	logic [15:0] shift_ff;
	logic hit_ff;
	logic [9:0] nxt_addr;

	assign nxt_addr = {addr_ff[8:0], mdio_bit};

	always_ff @(posedge mclk) begin
		if (reset) begin
			state_ff <= ST_PREAMBLE;
			pre_cnt_ff <= 6'h00;
			bit_cnt_ff <= 4'h0;
			op_ff <= 2'h0;
			addr_ff <= 10'h000;
			shift_ff <= 16'h0000;
			hit_ff <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
			rd_clr_ff <= 1'b0;
			wr_strobe_ff <= 1'b0;
			wr_reg_ff <= 5'h00;
			wr_data_ff <= 16'h0000;
		end else begin
			rd_clr_ff <= 1'b0;
			wr_strobe_ff <= 1'b0;
			if (mdc_rise) begin
				case (state_ff)
					ST_PREAMBLE: begin
						mdio_oe <= 1'b0;
						if (mdio_bit) begin
							if (pre_cnt_ff != PREAMBLE_ONES) begin
								pre_cnt_ff <= pre_cnt_ff + 6'h01;
							end
						end else begin
							// This zero is the first start bit
							if (pre_cnt_ff == PREAMBLE_ONES) begin
								state_ff <= ST_START;
							end
							pre_cnt_ff <= 6'h00;
						end
					end
					ST_START: begin
						state_ff <= mdio_bit ? ST_OPCODE : ST_PREAMBLE;
						bit_cnt_ff <= 4'h0;
					end
					ST_OPCODE: begin
						op_ff <= {op_ff[0], mdio_bit};
						if (bit_cnt_ff == 4'h1) begin
							bit_cnt_ff <= 4'h0;
							state_ff <= ST_ADDRESS;
						end else begin
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end
					end
					ST_ADDRESS: begin
						addr_ff <= nxt_addr;
						if (bit_cnt_ff == ADDR_BITS_LAST) begin
							bit_cnt_ff <= 4'h0;
							hit_ff <= (nxt_addr[9:5] == PHY_ADDRESS);
							if (op_ff != OP_READ && op_ff != OP_WRITE) begin
								state_ff <= ST_PREAMBLE;
							end else begin
								state_ff <= ST_TURNAROUND;
							end
							// Capture now and clear one cycle later: an event landing
							// later stays flagged for the next read
							if (op_ff == OP_READ && nxt_addr[9:5] == PHY_ADDRESS) begin
								shift_ff <= read_word(nxt_addr[4:0]);
								rd_clr_ff <= (nxt_addr[4:0] == ADDR_INT_ENABLE_AND_FLAGS);
							end
						end else begin
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end
					end
					ST_TURNAROUND: begin
						if (bit_cnt_ff == 4'h0) begin
							bit_cnt_ff <= 4'h1;
							if (op_ff == OP_READ && hit_ff) begin
								mdio_oe <= 1'b1;
								mdio_out <= 1'b0;
							end
						end else begin
							bit_cnt_ff <= 4'h0;
							state_ff <= ST_DATA;
							if (op_ff == OP_READ && hit_ff) begin
								mdio_out <= shift_ff[15];
								shift_ff <= {shift_ff[14:0], 1'b0};
							end
						end
					end
					ST_DATA: begin
						if (op_ff == OP_WRITE) begin
							shift_ff <= {shift_ff[14:0], mdio_bit};
						end else if (bit_cnt_ff != DATA_BITS_LAST) begin
							mdio_out <= shift_ff[15];
							shift_ff <= {shift_ff[14:0], 1'b0};
						end
						if (bit_cnt_ff == DATA_BITS_LAST) begin
							mdio_oe <= 1'b0;
							mdio_out <= 1'b0;
							bit_cnt_ff <= 4'h0;
							pre_cnt_ff <= 6'h00;
							state_ff <= ST_PREAMBLE;
							if (op_ff == OP_WRITE && hit_ff) begin
								wr_strobe_ff <= 1'b1;
								wr_reg_ff <= addr_ff[4:0];
								wr_data_ff <= {shift_ff[14:0], mdio_bit};
							end
						end else begin
							bit_cnt_ff <= bit_cnt_ff + 4'h1;
						end
					end
					default: begin
						state_ff <= ST_PREAMBLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt pin
	// ----------------------------------------------------------------
	logic int_active;

	assign int_active = |(ef.flags & int_en_ff);

	// Resets to the inactive level of the active-low default
	always_ff @(posedge mclk) begin
		if (reset) begin
			int_pin <= 1'b1;
		end else begin
			int_pin <= int_level_ff ? int_active : ~int_active;
		end
	end

	// ----------------------------------------------------------------
	// Crossover and jabber controls
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (reset) begin
			auto_crossover_en <= 1'b1;
			force_mdi <= 1'b0;
			force_mdix <= 1'b0;
			jabber_count_en <= RST_JABBER_EN;
		end else begin
			auto_crossover_en <= ~xover_off_ff;
			force_mdi <= xover_off_ff & xover_select_ff;
			force_mdix <= xover_off_ff & ~xover_select_ff;
			jabber_count_en <= jabber_en_ff;
		end
	end
endmodule : phy_mgmt_regs

// file: hdl/phy_regs_pkg.sv
// Constants shared by the management register bank and its helpers.
// Assumes a standard serial management frame on the management pins.
package phy_regs_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_INT_ENABLE_AND_FLAGS = 5'h1B;
	localparam logic [4:0] ADDR_CROSSOVER_CONTROL = 5'h1C;
	localparam logic [4:0] ADDR_PHY_CONTROL_AND_STATUS = 5'h1F;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NUM_EVENTS = 8;
	localparam int INT_EN_LSB = 8;
	localparam int INT_FLAG_LSB = 0;
	localparam int XOVER_SELECT_BIT = 7;
	localparam int XOVER_OFF_BIT = 6;
	localparam int CTL_INT_LEVEL_BIT = 14;
	localparam int CTL_JABBER_EN_BIT = 9;
	localparam int CTL_SPEED_1000_BIT = 6;
	localparam int CTL_SPEED_100_BIT = 5;
	localparam int CTL_SPEED_10_BIT = 4;
	localparam int CTL_DUPLEX_BIT = 3;
	localparam int CTL_MASTER_BIT = 2;
	localparam int CTL_LINK_FAIL_BIT = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INT_ENABLES = 8'h00;
	localparam logic [7:0] RST_INT_FLAGS = 8'h00;
	localparam logic RST_XOVER_SELECT = 1'b0;
	localparam logic RST_XOVER_OFF = 1'b0;
	localparam logic RST_INT_LEVEL = 1'b0;
	localparam logic RST_JABBER_EN = 1'b1;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;

	// ----------------------------------------------------------------
	// Management frame
	// ----------------------------------------------------------------
	localparam logic [5:0] PREAMBLE_ONES = 6'h20;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ = 2'h2;
	localparam logic [3:0] ADDR_BITS_LAST = 4'h9;
	localparam logic [3:0] DATA_BITS_LAST = 4'hF;

	typedef enum logic [2:0] {
		ST_PREAMBLE,
		ST_START,
		ST_OPCODE,
		ST_ADDRESS,
		ST_TURNAROUND,
		ST_DATA
	} frame_state_e;

endpackage : phy_regs_pkg

// file: hdl/event_flag_if.sv
// Carries event pulses, the read-clear strobe and the sticky flags
// between the register bank and the flag store; all on one clock.
`timescale 1ns/1ps
interface event_flag_if;
	import phy_regs_pkg::*;
	logic [NUM_EVENTS-1:0] evt;
	logic rd_clr;
	logic [NUM_EVENTS-1:0] flags;
	modport store (input evt, input rd_clr, output flags);
	modport owner (output evt, output rd_clr, input flags);
endinterface : event_flag_if

// file: hdl/sync_two_ff.sv
// Two-flop synchroniser for levels arriving from outside the mclk domain.
// Assumes nothing but a free running mclk.
`timescale 1ns/1ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge mclk) begin
		if (reset) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule : sync_two_ff

// file: hdl/event_flag_store.sv
// Sticky event flags, cleared by a register read.
// Assumes event pulses and the clear strobe are synchronous to mclk.
`timescale 1ns/1ps
module event_flag_store (
	input wire logic mclk,
	input wire logic reset,
	event_flag_if.store ef
);
	import phy_regs_pkg::*;

	logic [NUM_EVENTS-1:0] flags_ff;

	// ----------------------------------------------------------------
	// Per-event flag
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives: set wins over clear
	for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
		always_ff @(posedge mclk) begin
			if (reset) begin
				flags_ff[i] <= RST_INT_FLAGS[i];
			end else if (ef.evt[i]) begin
				flags_ff[i] <= 1'b1;
			end else if (ef.rd_clr) begin
				flags_ff[i] <= 1'b0;
			end
		end
	end

	assign ef.flags = flags_ff;
endmodule : event_flag_store

// file: tb/phy_mgmt_regs_assertions.sv
// Concurrent checks on the register bank's ports.
// Assumes mdc and events change on the falling mclk edge.
`timescale 1ns/1ps
module phy_mgmt_regs_assertions (
	input wire logic mclk,
	input wire logic reset,
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic evt_jabber,
	input wire logic evt_rx_error,
	input wire logic evt_page_received,
	input wire logic evt_parallel_fault,
	input wire logic evt_partner_ack,
	input wire logic evt_link_down,
	input wire logic evt_remote_fault,
	input wire logic evt_link_up,
	input wire logic int_pin,
	input wire logic auto_crossover_en,
	input wire logic force_mdi,
	input wire logic force_mdix,
	input wire logic jabber_count_en
);
	// ----------------------------------------
	// Quiet-time counters
	// ----------------------------------------
	logic any_evt;
	logic [4:0] calm_ff;
	logic [4:0] rise_ff;
	assign any_evt = evt_jabber | evt_rx_error | evt_page_received | evt_parallel_fault
		| evt_partner_ack | evt_link_down | evt_remote_fault | evt_link_up;
	// Outputs may only move shortly after management or event activity
	always_ff @(posedge mclk) begin
		if (reset || $changed(mdc) || any_evt) calm_ff <= 5'h00;
		else if (calm_ff != 5'h1F) calm_ff <= calm_ff + 5'h01;
	end
	always_ff @(posedge mclk) begin
		if (reset || $rose(mdc)) rise_ff <= 5'h00;
		else if (rise_ff != 5'h1F) rise_ff <= rise_ff + 5'h01;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	AST_RESET_OUT: assert property (
		disable iff (1'h0) reset |=> int_pin && auto_crossover_en && jabber_count_en && !mdio_oe)
		else $error("outputs not at reset level");
	AST_XOVER_AUTO: assert property (
		auto_crossover_en |-> !force_mdi && !force_mdix)
		else $error("forced mode while automatic crossover");
	AST_XOVER_FORCED: assert property (
		!auto_crossover_en |-> force_mdi != force_mdix)
		else $error("forced mode not one-hot");
	AST_INT_CAUSE: assert property (
		$changed(int_pin) |-> calm_ff < 5'h0C)
		else $error("interrupt moved without cause");
	AST_JAB_CAUSE: assert property (
		$changed(jabber_count_en) |-> calm_ff < 5'h0C)
		else $error("jabber enable moved without write");
	AST_XOVER_CAUSE: assert property (
		$changed(auto_crossover_en) || $changed(force_mdi) |-> calm_ff < 5'h0C)
		else $error("crossover moved without write");
	AST_OE_PHASE: assert property (
		$changed(mdio_oe) |-> rise_ff < 5'h08)
		else $error("data enable moved off an mdc rise");
	AST_TA_LOW: assert property (
		$rose(mdio_oe) |-> !mdio_out [*3])
		else $error("turnaround bit not low");
endmodule : phy_mgmt_regs_assertions

// file: tb/mdio_host_model.sv
// Station management host: clocks whole frames, releases data in reads.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
module mdio_host_model (
	input wire logic mclk,
	input wire logic mdio_wire,
	output logic mdc,
	output logic host_out,
	output logic host_oe
);
	import phy_regs_pkg::*;
	initial begin
		mdc = 1'h0;
		host_out = 1'h1;
		host_oe = 1'h0;
	end
	// mdc halves of 5 mclk keep clear of the 4-cycle minimum; mdc rests low between frames
	task automatic frame(input logic [4:0] phy, input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] f;
		f = {32'hFFFFFFFF, 2'h1, op, phy, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			host_oe = !(op == OP_READ && i < 18);
			host_out = f[i];
			repeat (5) @(negedge mclk);
			rd = {rd[14:0], mdio_wire};
			mdc = 1'h1;
			repeat (5) @(negedge mclk);
			mdc = 1'h0;
		end
		host_oe = 1'h0;
	endtask : frame
endmodule : mdio_host_model

// file: tb/phy_mgmt_regs_tb.sv
// Self-checking bench for the management register bank.
// Assumes the package constants and a pulled-up data wire.
`timescale 1ns/1ps
module phy_mgmt_regs_tb;
	import phy_regs_pkg::*;
	logic mclk, reset, mdc, mdio_wire, mdio_out, mdio_oe, host_out, host_oe;
	logic int_pin, auto_crossover_en, force_mdi, force_mdix, jabber_count_en;
	logic [7:0] evt, en;
	logic [5:0] st;
	logic [15:0] rd, d;
	logic p;
	int miscompares, tests_run, seed;
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	assign mdio_wire = host_oe ? host_out : (mdio_oe ? mdio_out : 1'h1);
	phy_mgmt_regs u_phy_mgmt_regs (.mclk(mclk), .reset(reset), .mdc(mdc), .mdio_in(mdio_wire),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .evt_jabber(evt[7]), .evt_rx_error(evt[6]),
		.evt_page_received(evt[5]), .evt_parallel_fault(evt[4]), .evt_partner_ack(evt[3]),
		.evt_link_down(evt[2]), .evt_remote_fault(evt[1]), .evt_link_up(evt[0]),
		.speed_1000(st[5]), .speed_100(st[4]), .speed_10(st[3]), .full_duplex(st[2]),
		.gig_master(st[1]), .link_check_fail(st[0]), .int_pin(int_pin),
		.auto_crossover_en(auto_crossover_en), .force_mdi(force_mdi), .force_mdix(force_mdix),
		.jabber_count_en(jabber_count_en));
	mdio_host_model u_mdio_host_model (.mclk(mclk), .mdio_wire(mdio_wire), .mdc(mdc),
		.host_out(host_out), .host_oe(host_oe));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		u_mdio_host_model.frame(5'h01, OP_WRITE, a, v, rd);
		repeat (8) @(negedge mclk);
	endtask : wr
	task automatic rdr(input logic [4:0] a);
		u_mdio_host_model.frame(5'h01, OP_READ, a, 16'h0000, rd);
		repeat (8) @(negedge mclk);
	endtask : rdr
	function automatic logic [15:0] ctl_exp(input logic [15:0] v, input logic [5:0] s);
		return {1'h0, v[14], 4'h0, v[9], 2'h0, s[5:1], 1'h0, s[0]};
	endfunction : ctl_exp
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		report_and_stop();
	end
	initial begin
		seed = 65;
		reset = 1'h1;
		evt = 8'h00;
		st = 6'h00;
		miscompares = 0;
		tests_run = 0;
		repeat (5) @(negedge mclk);
		reset = 1'h0;
		chk("pins", 16'h0019, {int_pin, auto_crossover_en, force_mdi, force_mdix, jabber_count_en});
		rdr(ADDR_INT_ENABLE_AND_FLAGS);
		chk("int reg reset", 16'h0000, rd);
		rdr(ADDR_PHY_CONTROL_AND_STATUS);
		chk("ctl reg reset", 16'h0200, rd);
		for (int i = 0; i < 4; i++) begin
			d = $random(seed);
			d[7:6] = i[1:0];
			wr(ADDR_CROSSOVER_CONTROL, d);
			rdr(ADDR_CROSSOVER_CONTROL);
			chk("xover reg", d & 16'h00C0, rd);
			chk("xover pins", {13'h0, !d[6], d[6] & d[7], d[6] & !d[7]},
				{13'h0, auto_crossover_en, force_mdi, force_mdix});
			d = $random(seed);
			d[14] = i[1];
			d[9] = i[0];
			st = $random(seed);
			wr(ADDR_PHY_CONTROL_AND_STATUS, d);
			rdr(ADDR_PHY_CONTROL_AND_STATUS);
			chk("ctl reg", ctl_exp(d, st), rd);
			chk("jabber en", {15'h0, d[9]}, {15'h0, jabber_count_en});
		end
		for (int i = 0; i < 8; i++) begin
			p = $random(seed);
			en = $random(seed);
			en[i] = i[0];
			wr(ADDR_PHY_CONTROL_AND_STATUS, {1'h0, p, 14'h0200});
			wr(ADDR_INT_ENABLE_AND_FLAGS, {en, 8'hFF});
			rdr(ADDR_INT_ENABLE_AND_FLAGS);
			chk("flags ro", {en, 8'h00}, rd);
			evt[i] = 1'h1;
			@(negedge mclk);
			evt = 8'h00;
			repeat (3) @(negedge mclk);
			chk("int on", {15'h0, p ? en[i] : !en[i]}, {15'h0, int_pin});
			rdr(ADDR_INT_ENABLE_AND_FLAGS);
			chk("flag set", {en, 8'h01 << i}, rd);
			chk("int off", {15'h0, !p}, {15'h0, int_pin});
			rdr(ADDR_INT_ENABLE_AND_FLAGS);
			chk("flag clear", {en, 8'h00}, rd);
		end
		u_mdio_host_model.frame(5'h02, OP_WRITE, ADDR_CROSSOVER_CONTROL, 16'h0040, rd);
		rdr(ADDR_CROSSOVER_CONTROL);
		chk("other phy write", 16'h00C0, rd);
		u_mdio_host_model.frame(5'h02, OP_READ, ADDR_CROSSOVER_CONTROL, 16'h0000, rd);
		chk("other phy read", 16'hFFFF, rd);
		u_mdio_host_model.frame(5'h01, 2'h3, ADDR_CROSSOVER_CONTROL, 16'h0000, rd);
		rdr(ADDR_CROSSOVER_CONTROL);
		chk("bad opcode", 16'h00C0, rd);
		wr(5'h10, 16'hFFFF);
		rdr(5'h10);
		chk("unmapped", 16'h0000, rd);
		reset = 1'h1;
		repeat (3) @(negedge mclk);
		reset = 1'h0;
		rdr(ADDR_CROSSOVER_CONTROL);
		chk("xover after reset", 16'h0000, rd);
		chk("pins after reset", 16'h0019,
			{int_pin, auto_crossover_en, force_mdi, force_mdix, jabber_count_en});
		report_and_stop();
	end
endmodule : phy_mgmt_regs_tb
bind phy_mgmt_regs phy_mgmt_regs_assertions u_phy_mgmt_regs_assertions (.mclk(mclk), .reset(reset),
	.mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .evt_jabber(evt_jabber),
	.evt_rx_error(evt_rx_error), .evt_page_received(evt_page_received),
	.evt_parallel_fault(evt_parallel_fault), .evt_partner_ack(evt_partner_ack),
	.evt_link_down(evt_link_down), .evt_remote_fault(evt_remote_fault), .evt_link_up(evt_link_up),
	.int_pin(int_pin), .auto_crossover_en(auto_crossover_en), .force_mdi(force_mdi),
	.force_mdix(force_mdix), .jabber_count_en(jabber_count_en));
